// *** rrx_exec.v ***
// execution unit for no-op, returns and rotate-left through carry
//
// Overview of operation
// - return-with-literal loads accumulator, pops pc, two cycles
// - return-with-literal also sets global interrupt enable
// - return-from-interrupt pops pc, sets enable, two cycles
// - plain return pops pc, no flags, two cycles
// - rotate left: carry into bit0, bit7 out
// - destination select 0 accumulator, 1 file register
`timescale 1ns/1ps
`include "rrx_defines.vh"
module rrx_exec (
   input  wire                   clk,         // core clock
   input  wire                   reset_n,     // async reset, active low
   input  wire                   opValid,     // one-cycle issue strobe
   input  wire [`RRX_OP_W-1:0]   opCode,      // instruction class
   input  wire [`RRX_DATA_W-1:0] immData,     // literal operand
   input  wire [`RRX_ADDR_W-1:0] regAddr,     // file register index
   input  wire                   destSel,     // rotate destination
   input  wire [`RRX_DATA_W-1:0] regData,     // source file register value
   input  wire [`RRX_PC_W-1:0]   stackTop,    // top of return stack
   input  wire                   carryIn,     // current carry flag
   output wire                   busy,        // second cycle of a return
   output wire                   done,        // instruction retired pulse
   output wire [`RRX_PC_W-1:0]   pc,          // program counter
   output wire                   stackPop,    // pop return stack pulse
   output wire [`RRX_DATA_W-1:0] accumulator, // accumulator
   output wire                   carryWe,     // carry write pulse
   output wire                   carryOut,    // new carry value
   output wire                   regWe,       // file register write pulse
   output wire [`RRX_ADDR_W-1:0] regWrAddr,   // file register write index
   output wire [`RRX_DATA_W-1:0] regWrData,   // file register write value
   output wire                   globalInterruptEnable // interrupt gate
);

   // sequencer states, binary coded
   localparam ST_IDLE = 1'h0;                 // accepting issue
   localparam ST_POP  = 1'h1;                 // second return cycle

   // sequencer and operand holding registers
   reg                    state_q;            // sequencer state
   reg                    state_d;            // next sequencer state
   reg  [`RRX_OP_W-1:0]   heldOp_q;           // return kind in flight
   reg  [`RRX_OP_W-1:0]   heldOp_d;           // next return kind
   reg  [`RRX_DATA_W-1:0] heldImm_q;          // literal waiting for cycle 2
   reg  [`RRX_DATA_W-1:0] heldImm_d;          // next held literal

   // output registers; each port is a plain copy of one of these
   reg                    busy_q;             // pop cycle in progress
   reg                    busy_d;             // next busy level
   reg                    done_q;             // retire pulse
   reg                    done_d;             // next retire pulse
   reg  [`RRX_PC_W-1:0]   pc_q;               // program counter
   reg  [`RRX_PC_W-1:0]   pc_d;               // next program counter
   reg                    stackPop_q;         // pop pulse to the stack
   reg                    stackPop_d;         // next pop pulse
   reg  [`RRX_DATA_W-1:0] accumulator_q;      // working register
   reg  [`RRX_DATA_W-1:0] accumulator_d;      // next working register
   reg                    carryWe_q;          // carry write pulse
   reg                    carryWe_d;          // next carry write pulse
   reg                    carryOut_q;         // last carry produced
   reg                    carryOut_d;         // next carry value
   reg                    regWe_q;            // file write pulse
   reg                    regWe_d;            // next file write pulse
   reg  [`RRX_ADDR_W-1:0] regWrAddr_q;        // file write index
   reg  [`RRX_ADDR_W-1:0] regWrAddr_d;        // next file write index
   reg  [`RRX_DATA_W-1:0] regWrData_q;        // file write value
   reg  [`RRX_DATA_W-1:0] regWrData_d;        // next file write value
   reg                    intEnable_q;        // gate; only ever set here
   reg                    intEnable_d;        // next gate level

   // wires feeding the next-state logic
   wire                   issueIdle;          // strobe seen while idle
   wire [`RRX_DATA_W-1:0] rotlRes;            // rotate result, both targets

   // rotate result: carry fills bit 0, bits 6..0 move up
   function [`RRX_DATA_W-1:0] rotl;
      input [`RRX_DATA_W-1:0] src;
      input                   cin;
      begin
         rotl = {src[`RRX_MSB-1:`RRX_LSB], cin};
      end
   endfunction

   // is this opcode one of the two-cycle returns
   function isReturn;
      input [`RRX_OP_W-1:0] op;
      begin
         isReturn = (op == `RRX_OP_RET) || (op == `RRX_OP_RETLIT) ||
                    (op == `RRX_OP_RETINT);
      end
   endfunction

   // is this opcode one of the one-cycle classes
   function isSingle;
      input [`RRX_OP_W-1:0] op;
      begin
         isSingle = (op == `RRX_OP_NOP) || (op == `RRX_OP_ROTL);
      end
   endfunction

   // a strobe in the pop cycle is dropped; the issuer must wait out busy
   assign issueIdle = opValid && (state_q == ST_IDLE);

   // one rotate network serves both destinations, saving a second copy
   assign rotlRes = rotl(regData, carryIn);

   // next-state logic; pulses fall low unless an event raises them
   always @* begin
      // hold every level by default; the four pulses clear
      state_d       = state_q;
      heldOp_d      = heldOp_q;
      heldImm_d     = heldImm_q;
      busy_d        = busy_q;
      done_d        = `RRX_BIT_CLR;
      pc_d          = pc_q;
      stackPop_d    = `RRX_BIT_CLR;
      accumulator_d = accumulator_q;
      carryWe_d     = `RRX_BIT_CLR;
      carryOut_d    = carryOut_q;
      regWe_d       = `RRX_BIT_CLR;
      regWrAddr_d   = regWrAddr_q;
      regWrData_d   = regWrData_q;
      intEnable_d   = intEnable_q;
      case (state_q)
         ST_IDLE: begin
            if (issueIdle && isReturn(opCode)) begin
               // first of two cycles: latch kind and literal
               state_d   = ST_POP;
               heldOp_d  = opCode;
               heldImm_d = immData;
               busy_d    = `RRX_BIT_SET;
            end else if (issueIdle && isSingle(opCode)) begin
               // one-cycle classes retire at once
               pc_d   = pc_q + `RRX_PC_STEP;
               done_d = `RRX_BIT_SET;
               if (opCode == `RRX_OP_ROTL) begin
                  // old top bit becomes the carry
                  carryWe_d  = `RRX_BIT_SET;
                  carryOut_d = regData[`RRX_MSB];
                  if (destSel == `RRX_DEST_ACCUM) begin
                     accumulator_d = rotlRes;
                  end else begin
                     // write back to the source register
                     regWe_d     = `RRX_BIT_SET;
                     regWrAddr_d = regAddr;
                     regWrData_d = rotlRes;
                  end
               end
            end else begin
               // no strobe, class none or unused code: stay put
               state_d = ST_IDLE;
            end
         end
         ST_POP: begin
            // second cycle: pc from stack; the stack is read only now
            state_d    = ST_IDLE;
            busy_d     = `RRX_BIT_CLR;
            done_d     = `RRX_BIT_SET;
            stackPop_d = `RRX_BIT_SET;
            pc_d       = stackTop;
            if (heldOp_q == `RRX_OP_RETLIT) begin
               accumulator_d = heldImm_q;
               intEnable_d   = `RRX_BIT_SET;
            end else if (heldOp_q == `RRX_OP_RETINT) begin
               intEnable_d   = `RRX_BIT_SET;
            end else begin
               // plain return: accumulator and enable untouched
               intEnable_d   = intEnable_q;
            end
         end
         default: begin
            // unreachable code: fall back to idle, drop the pop
            state_d = ST_IDLE;
            busy_d  = `RRX_BIT_CLR;
         end
      endcase
   end

   // state registers; reset loads constants only
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q       <= ST_IDLE;
         heldOp_q      <= `RRX_OP_NONE;
         heldImm_q     <= `RRX_DATA_RST;
         busy_q        <= `RRX_BIT_CLR;
         done_q        <= `RRX_BIT_CLR;
         pc_q          <= `RRX_PC_RST;
         stackPop_q    <= `RRX_BIT_CLR;
         accumulator_q <= `RRX_DATA_RST;
         carryWe_q     <= `RRX_BIT_CLR;
         carryOut_q    <= `RRX_BIT_CLR;
         regWe_q       <= `RRX_BIT_CLR;
         regWrAddr_q   <= `RRX_ADDR_RST;
         regWrData_q   <= `RRX_DATA_RST;
         intEnable_q   <= `RRX_BIT_CLR;
      end else begin
         state_q       <= state_d;
         heldOp_q      <= heldOp_d;
         heldImm_q     <= heldImm_d;
         busy_q        <= busy_d;
         done_q        <= done_d;
         pc_q          <= pc_d;
         stackPop_q    <= stackPop_d;
         accumulator_q <= accumulator_d;
         carryWe_q     <= carryWe_d;
         carryOut_q    <= carryOut_d;
         regWe_q       <= regWe_d;
         regWrAddr_q   <= regWrAddr_d;
         regWrData_q   <= regWrData_d;
         intEnable_q   <= intEnable_d;
      end
   end

   // ports are plain copies of flip-flops, no logic after the register
   assign busy                  = busy_q;
   assign done                  = done_q;
   assign pc                    = pc_q;
   assign stackPop              = stackPop_q;
   assign accumulator           = accumulator_q;
   assign carryWe               = carryWe_q;
   assign carryOut              = carryOut_q;
   assign regWe                 = regWe_q;
   assign regWrAddr             = regWrAddr_q;
   assign regWrData             = regWrData_q;
   assign globalInterruptEnable = intEnable_q;

endmodule

// *** rrx_defines.vh ***
// constants for the return and rotate execution block
`ifndef RRX_DEFINES_VH
`define RRX_DEFINES_VH
`define RRX_PC_W        10
`define RRX_DATA_W      8
`define RRX_ADDR_W      6
`define RRX_OP_W        3
`define RRX_OP_NONE     3'h0
`define RRX_OP_NOP      3'h1
`define RRX_OP_RET      3'h2
`define RRX_OP_RETLIT   3'h3
`define RRX_OP_RETINT   3'h4
`define RRX_OP_ROTL     3'h5
// rotate destination select
`define RRX_DEST_ACCUM  1'h0
`define RRX_DEST_REG    1'h1
// pc step, reset values, single-bit levels, bit positions
`define RRX_PC_STEP     10'h001
`define RRX_DATA_RST    8'h00
`define RRX_PC_RST      10'h000
`define RRX_ADDR_RST    6'h00
`define RRX_BIT_CLR     1'h0
`define RRX_BIT_SET     1'h1
`define RRX_MSB         7
`define RRX_LSB         0
`endif

// *** rrx_exec_sva.sv ***
// assertion checker for the return and rotate execution unit
`timescale 1ns/1ps
`include "rrx_defines.vh"
module rrx_exec_sva (
   input wire                   clk,
   input wire                   reset_n,
   input wire                   opValid,
   input wire [`RRX_OP_W-1:0]   opCode,
   input wire [`RRX_DATA_W-1:0] immData,
   input wire [`RRX_ADDR_W-1:0] regAddr,
   input wire                   destSel,
   input wire [`RRX_DATA_W-1:0] regData,
   input wire [`RRX_PC_W-1:0]   stackTop,
   input wire                   carryIn,
   input wire                   busy,
   input wire                   done,
   input wire [`RRX_PC_W-1:0]   pc,
   input wire                   stackPop,
   input wire [`RRX_DATA_W-1:0] accumulator,
   input wire                   carryWe,
   input wire                   carryOut,
   input wire                   regWe,
   input wire [`RRX_ADDR_W-1:0] regWrAddr,
   input wire [`RRX_DATA_W-1:0] regWrData,
   input wire                   globalInterruptEnable
);
   wire ok = opValid && !busy; // issue taken, not refused
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_nop_only_pc: assert property (
      ok && opCode == `RRX_OP_NOP |=> done && !regWe && !carryWe &&
      $stable(accumulator) && pc == $past(pc) + `RRX_PC_STEP)
      else $error("nop changed more than pc");
   a_rotl_carry: assert property (
      ok && opCode == `RRX_OP_ROTL |=> done && !busy && carryWe &&
      carryOut == $past(regData[`RRX_MSB]))
      else $error("rotate carry out wrong");
   a_rotl_dest: assert property (
      ok && opCode == `RRX_OP_ROTL |=> regWe == $past(destSel) &&
      (regWe ? regWrData : accumulator) ==
      {$past(regData[`RRX_MSB-1:0]), $past(carryIn)})
      else $error("rotate result wrong");
   a_rotl_addr: assert property (
      ok && opCode == `RRX_OP_ROTL && destSel |=>
      regWe && regWrAddr == $past(regAddr))
      else $error("rotate write index wrong");
   a_retlit_load: assert property (
      ok && opCode == `RRX_OP_RETLIT |=> busy ##1 done && stackPop &&
      pc == $past(stackTop) && accumulator == $past(immData, 2))
      else $error("return with literal wrong");
   a_retlit_enable: assert property (
      ok && opCode == `RRX_OP_RETLIT |=> ##1 globalInterruptEnable)
      else $error("return with literal left interrupts off");
   a_retint_enable: assert property (
      ok && opCode == `RRX_OP_RETINT |=> busy ##1 done && stackPop &&
      globalInterruptEnable && pc == $past(stackTop))
      else $error("return from interrupt wrong");
   a_ret_noflag: assert property (
      ok && opCode == `RRX_OP_RET |=> busy ##1 done && stackPop &&
      !carryWe && $stable(globalInterruptEnable) &&
      $stable(accumulator) && pc == $past(stackTop))
      else $error("plain return wrong");
endmodule

// *** rrx_exec_tb_top.sv ***
// self-checking bench for the return and rotate execution unit
`timescale 1ns/1ps
module rrx_exec_tb_top;
   reg clk = 0, reset_n = 0, opValid = 0, destSel = 0, carryIn = 0, mGie;
   reg [2:0] opCode = 0;
   reg [7:0] immData = 0, regData = 0, mAcc, res;
   reg [5:0] regAddr = 0;
   reg [9:0] stackTop = 0, mPc;
   wire busy, done, stackPop, carryWe, carryOut, regWe, globalInterruptEnable;
   wire [9:0] pc;
   wire [7:0] accumulator, regWrData;
   wire [5:0] regWrAddr;
   integer n_fail = 0, compares = 0, cyc = 0, i, t;
   always #2 clk = ~clk; // 4 ns period
   rrx_exec DUT (
      .clk                   (clk),
      .reset_n               (reset_n),
      .opValid               (opValid),
      .opCode                (opCode),
      .immData               (immData),
      .regAddr               (regAddr),
      .destSel               (destSel),
      .regData               (regData),
      .stackTop              (stackTop),
      .carryIn               (carryIn),
      .busy                  (busy),
      .done                  (done),
      .pc                    (pc),
      .stackPop              (stackPop),
      .accumulator           (accumulator),
      .carryWe               (carryWe),
      .carryOut              (carryOut),
      .regWe                 (regWe),
      .regWrAddr             (regWrAddr),
      .regWrData             (regWrData),
      .globalInterruptEnable (globalInterruptEnable)
   );
   task chk(input [15:0] g, input [15:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task stop_test;
      begin
         $display("compares %0d fails %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   // one instruction, driven on falling edges, checked against the model
   task run(input [2:0] o);
      begin
         @(negedge clk);
         {immData, regData, stackTop} = 26'($urandom);
         {carryIn, destSel, regAddr} = 8'($urandom);
         opValid = 1;
         opCode = o;
         res = {regData[6:0], carryIn};
         @(negedge clk);
         opValid = 0;
         if (o > 1 && o < 5) chk(busy, 1);
         if (o > 1 && o < 5) @(negedge clk);
         chk(done, o != 0);
         if (o == 1 || o == 5) mPc = mPc + 1;
         if (o > 1 && o < 5) mPc = stackTop;
         if (o == 3) mAcc = immData;
         if (o == 3 || o == 4) mGie = 1;
         if (o == 5 && !destSel) mAcc = res;
         if (o == 5) chk(carryOut, regData[7]);
         chk(regWe, o == 5 && destSel);
         if (o == 5 && destSel) chk(regWrData, res);
         if (o == 5 && destSel) chk(regWrAddr, regAddr);
         chk(stackPop, o > 1 && o < 5);
         chk(carryWe, o == 5);
         chk(pc, mPc);
         chk(accumulator, mAcc);
         chk(globalInterruptEnable, mGie);
      end
   endtask
   // cycle ceiling well above the three short tests
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 1000) begin
         n_fail = n_fail + 1;
         stop_test;
      end
   end
   // each test resets, opens with one return kind, then random traffic
   initial begin
      i = $urandom(32'h39378FBF);
      for (t = 2; t < 5; t = t + 1) begin
         reset_n = 0;
         {mPc, mAcc, mGie} = 0;
         repeat (16) @(negedge clk);
         reset_n = 1;
         run(t[2:0]);
         for (i = 0; i < 20; i = i + 1) run(3'($urandom % 6));
         $display("test %0d done", t);
      end
      stop_test;
   end
endmodule
bind rrx_exec rrx_exec_sva u_sva (
   .clk                   (clk),
   .reset_n               (reset_n),
   .opValid               (opValid),
   .opCode                (opCode),
   .immData               (immData),
   .regAddr               (regAddr),
   .destSel               (destSel),
   .regData               (regData),
   .stackTop              (stackTop),
   .carryIn               (carryIn),
   .busy                  (busy),
   .done                  (done),
   .pc                    (pc),
   .stackPop              (stackPop),
   .accumulator           (accumulator),
   .carryWe               (carryWe),
   .carryOut              (carryOut),
   .regWe                 (regWe),
   .regWrAddr             (regWrAddr),
   .regWrData             (regWrData),
   .globalInterruptEnable (globalInterruptEnable)
);
